//--- hw/transfer_error_monitor.v
// error detection and summary for the drive-bus transfer controller
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "transfer_error_monitor_map.vh"
module transfer_error_monitor #(
   parameter TIMEOUT_CYC = `TIMEOUT_CYC
) (
   input  wire                clk_in,
   input  wire                rst_n_in,
   input  wire [`ADDR_W-1:0]  addr_in,
   input  wire [15:0]         wdata_in,
   input  wire                wr_in,
   input  wire                rd_in,
   output reg  [15:0]         rdata_out,
   input  wire                bus_init_in,
   input  wire                power_fail_in,
   input  wire                drive_engaged_in,
   input  wire                end_of_block_in,
   input  wire                drive_fault_line_in,
   input  wire                word_strobe_in,
   input  wire                drive_attention_in,
   input  wire                control_bus_parity_fault_in,
   input  wire                compare_mismatch_in,
   input  wire                parity_fault_in,
   input  wire                absent_drive_in,
   input  wire                absent_memory_in,
   input  wire                program_fault_in,
   input  wire                data_bus_parity_fault_in,
   input  wire                inbound_full_in,
   input  wire                staging_valid_in,
   input  wire                drive_count_done_in,
   input  wire                buffer_drained_in,
   input  wire                last_word_in,
   input  wire                pair_pending_in,
   output wire                single_word_force_out,
   output wire                interrupt_req_out,
   output wire                error_clear_pulse_out,
   output reg                 post_strobe_out
);
   // reset release
   reg rst_a_q, rst_b_q;
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_a_q <= 1'b0;
         rst_b_q <= 1'b0;
      end else begin
         rst_a_q <= 1'b1;
         rst_b_q <= rst_a_q;
      end
   end
   wire rst_n = rst_b_q;

   // external pins through two flops
   wire [7:0] pin_raw = {drive_engaged_in, end_of_block_in,
                         drive_fault_line_in, word_strobe_in,
                         drive_attention_in, control_bus_parity_fault_in,
                         bus_init_in, power_fail_in};
   wire [7:0] pin_s;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_sync
         sync2 u_sync (
            .clk_in   (clk_in),
            .rst_n_in (rst_n),
            .d_in     (pin_raw[g]),
            .q_out    (pin_s[g])
         );
      end
   endgenerate
   wire engaged_s = pin_s[7];
   wire eob_s     = pin_s[6];
   wire fault_s   = pin_s[5];
   wire strobe_s  = pin_s[4];
   wire drive_attention_s    = pin_s[3];
   wire cpar_s    = pin_s[2];
   wire init_s    = pin_s[1];
   wire pfail_s   = pin_s[0];

   reg eob_d1_q, strobe_d1_q, engaged_d1_q;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         eob_d1_q     <= 1'b0;
         strobe_d1_q  <= 1'b0;
         engaged_d1_q <= 1'b0;
      end else begin
         eob_d1_q     <= eob_s;
         strobe_d1_q  <= strobe_s;
         engaged_d1_q <= engaged_s;
      end
   end
   wire eob_rise     = eob_s & ~eob_d1_q;
   wire strobe_fall  = ~strobe_s & strobe_d1_q;

   // software registers
   reg busy_q, read_q, wrchk_q, write_q, ie_q;
   reg mxf_q;
   wire wr_cs1 = wr_in & (addr_in == `CS1_ADDR);
   wire wr_cs2 = wr_in & (addr_in == `CS2_ADDR);
   wire wr_cmd = wr_in & (addr_in == `CMD_ADDR);
   wire tre_write = wr_cs1 & wdata_in[`CS1_TRE_BIT];
   reg  clr_q;
   wire clr_req = init_s | pfail_s | tre_write |
                  (wr_cs2 & wdata_in[`CS2_CLR_BIT]);
   assign error_clear_pulse_out = clr_q;
   wire clr = clr_q;

   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         clr_q   <= 1'b0;
         busy_q  <= 1'b0;
         read_q  <= 1'b0;
         wrchk_q <= 1'b0;
         write_q <= 1'b0;
         ie_q    <= `IE_RESET;
      end else begin
         clr_q <= clr_req;
         if (wr_cs1)
            ie_q <= wdata_in[`CS1_IE_BIT];
         if (wr_cmd) begin
            busy_q  <= wdata_in[`CMD_BUSY_BIT];
            read_q  <= wdata_in[`CMD_READ_BIT];
            wrchk_q <= wdata_in[`CMD_WRCHK_BIT];
            write_q <= wdata_in[`CMD_WRITE_BIT];
         end else if (mxf_q)
            busy_q <= 1'b0; // missed transfer ends the command
      end
   end

   // missed transfer timing
   wire timer_run = busy_q & ~engaged_s & ~mxf_q &
                    (engaged_d1_q | ~strobe_s);
   reg timer_armed_q;
   wire expired;
   timeout_counter #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_timer (
      .clk_in      (clk_in),
      .rst_n_in    (rst_n),
      .run_in      (timer_run | timer_armed_q),
      .expired_out (expired)
   );
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         timer_armed_q <= 1'b0;
         mxf_q         <= 1'b0;
      end else begin
         // stays armed until engaged or busy drops; word strobe later is moot
         timer_armed_q <= busy_q & ~engaged_s & (timer_run | timer_armed_q);
         if (engaged_s)
            mxf_q <= 1'b0;
         else if (expired & busy_q)
            mxf_q <= 1'b1;
         else if (clr)
            mxf_q <= 1'b0;
      end
   end

   // post-strobe pulse and data late
   reg [3:0] pulse_cnt_q;
   reg       late_sync_stage_q, data_late_flag_q;
   wire late_cond = ((read_q | wrchk_q) & inbound_full_in) |
                    (write_q & ~staging_valid_in &
                     ~drive_count_done_in);
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pulse_cnt_q       <= 4'h0;
         post_strobe_out   <= 1'b0;
         late_sync_stage_q <= 1'b0;
         data_late_flag_q  <= 1'b0;
      end else begin
         if (strobe_fall) begin
            pulse_cnt_q     <= `PULSE_CYC;
            post_strobe_out <= 1'b1;
         end else if (pulse_cnt_q != 4'h0) begin
            pulse_cnt_q     <= pulse_cnt_q - 4'h1;
            post_strobe_out <= (pulse_cnt_q != 4'h1);
         end
         // a late word in the clear cycle still counts
         if (post_strobe_out & late_cond)
            late_sync_stage_q <= 1'b1;
         else if (clr)
            late_sync_stage_q <= 1'b0;
         if (post_strobe_out & (pulse_cnt_q == 4'h1) &
             late_sync_stage_q)
            data_late_flag_q <= 1'b1;
         else if (clr)
            data_late_flag_q <= 1'b0;
      end
   end

   // drive fault capture
   reg drive_fault_latch_q;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n)
         drive_fault_latch_q <= 1'b0;
      else if (eob_rise & fault_s)
         drive_fault_latch_q <= 1'b1;
      else if (clr)
         drive_fault_latch_q <= 1'b0;
   end
   wire read_fault_pending = read_q & drive_fault_latch_q;
   wire drive_fault_error = ((write_q | wrchk_q) & drive_fault_latch_q) |
                            (read_fault_pending & buffer_drained_in);
   assign single_word_force_out = read_fault_pending & last_word_in &
                                  pair_pending_in;

   // transfer error summary
   reg transfer_error_q;
   reg err_any_q;
   wire err_any = compare_mismatch_in | parity_fault_in |
                  data_late_flag_q | absent_drive_in | absent_memory_in |
                  program_fault_in | mxf_q | data_bus_parity_fault_in |
                  drive_fault_error;
   // set on a new error only: latched sources fall with the same clear,
   // so a level set would pin the summary high for ever
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         transfer_error_q <= 1'b0;
         err_any_q        <= 1'b0;
      end else begin
         err_any_q <= err_any;
         if (err_any & ~err_any_q)
            transfer_error_q <= 1'b1;
         else if (clr | tre_write)
            transfer_error_q <= 1'b0;
      end
   end
   wire special_condition = transfer_error_q | drive_attention_s | cpar_s;
   // ready gating keeps the handler from running mid-transfer
   assign interrupt_req_out = special_condition & ie_q & ~busy_q;

   // read port, data one cycle after strobe
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n)
         rdata_out <= 16'h0;
      else if (rd_in) begin
         rdata_out <= 16'h0;
         case (addr_in)
            `CS1_ADDR: begin
               rdata_out[`CS1_SC_BIT]  <= special_condition;
               rdata_out[`CS1_TRE_BIT] <= transfer_error_q;
               rdata_out[`CS1_RDY_BIT] <= ~busy_q;
               rdata_out[`CS1_IE_BIT]  <= ie_q;
            end
            `CS2_ADDR: begin
               rdata_out[`CS2_DLT_BIT] <= data_late_flag_q;
               rdata_out[`CS2_MXF_BIT] <= mxf_q;
            end
            `CMD_ADDR:
               rdata_out[3:0] <= {write_q, wrchk_q, read_q, busy_q};
            default:
               rdata_out <= 16'h0;
         endcase
      end
   end
endmodule // transfer_error_monitor

//--- inc/transfer_error_monitor_map.vh
// constants for the transfer error monitor
`ifndef TRANSFER_ERROR_MONITOR_MAP_VH
`define TRANSFER_ERROR_MONITOR_MAP_VH
`define ADDR_W            4
`define CS1_ADDR          4'h0
`define CS2_ADDR          4'h1
`define CMD_ADDR          4'h2
`define CS1_TRE_BIT       14
`define CS1_SC_BIT        15
`define CS1_IE_BIT        6
`define CS1_RDY_BIT       7
`define CS2_DLT_BIT       15
`define CS2_MXF_BIT       9
`define CS2_CLR_BIT       5
`define CMD_BUSY_BIT      0
`define CMD_READ_BIT      1
`define CMD_WRCHK_BIT     2
`define CMD_WRITE_BIT     3
`define TIMEOUT_US        650
`define CLK_MHZ           200
`define TIMEOUT_CYC       (`TIMEOUT_US * `CLK_MHZ)
`define PULSE_CYC         4'ha
`define IE_RESET          1'b0
`endif

//--- hw/sync2.v
// two flip-flop synchroniser for one level
`timescale 1ns/1ps
module sync2 (
   input  wire clk_in,
   input  wire rst_n_in,
   input  wire d_in,
   output reg  q_out
);
   reg meta_q;
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         meta_q <= 1'b0;
         q_out  <= 1'b0;
      end else begin
         meta_q <= d_in;
         q_out  <= meta_q;
      end
   end
endmodule // sync2

//--- hw/timeout_counter.v
// up counter that times the wait for drive engaged
`timescale 1ns/1ps
`include "transfer_error_monitor_map.vh"
module timeout_counter #(
   parameter TIMEOUT_CYC = `TIMEOUT_CYC
) (
   input  wire clk_in,
   input  wire rst_n_in,
   input  wire run_in,
   output reg  expired_out
);
   // counter is 18 bits wide, so the timeout must not exceed 262144 cycles
   localparam [31:0] TERM_FULL = TIMEOUT_CYC - 1;
   localparam [17:0] TERM      = TERM_FULL[17:0];
   reg [17:0] cnt_q;
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_q       <= 18'h0;
         expired_out <= 1'b0;
      end else if (!run_in) begin
         cnt_q       <= 18'h0;
         expired_out <= 1'b0;
      end else if (cnt_q == TERM) begin
         expired_out <= 1'b1;
      end else begin
         cnt_q       <= cnt_q + 18'h1;
         expired_out <= 1'b0;
      end
   end
endmodule // timeout_counter

//--- verification/err_check_monitor.sv
// port-level assertions for the transfer error monitor
`timescale 1ns/1ps
module err_checker (
   input wire        clk_in,
   input wire        rst_n_in,
   input wire [3:0]  addr_in,
   input wire [15:0] wdata_in,
   input wire        wr_in,
   input wire        rd_in,
   input wire [15:0] rdata_out,
   input wire        bus_init_in,
   input wire        power_fail_in,
   input wire        last_word_in,
   input wire        pair_pending_in,
   input wire        single_word_force_out,
   input wire        interrupt_req_out,
   input wire        error_clear_pulse_out,
   input wire        post_strobe_out
);
   wire clr_seen = error_clear_pulse_out;
   wire irq_rd = rd_in && addr_in == 4'h0 && interrupt_req_out;
   default clocking dc @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   a_tre_write_clears: assert property (
      wr_in && addr_in == 4'h0 && wdata_in[14] |-> ##[1:2] clr_seen)
      else $error("no clear after bit 14 write");
   a_cs2_bit_clears: assert property (
      wr_in && addr_in == 4'h1 && wdata_in[5] |-> ##[1:2] clr_seen)
      else $error("no clear after bit 5 write");
   // init and power fail cross two sync flops first
   a_init_clears: assert property (
      $rose(bus_init_in) |-> ##[1:6] clr_seen)
      else $error("no clear after init");
   a_pfail_clears: assert property (
      $rose(power_fail_in) |-> ##[1:6] clr_seen)
      else $error("no clear after power fail");
   a_force_cause: assert property (
      single_word_force_out |-> last_word_in && pair_pending_in)
      else $error("single word forced without cause");
   a_post_width: assert property (
      $rose(post_strobe_out) |-> post_strobe_out[*8] ##1
      post_strobe_out[*2] ##1 !post_strobe_out)
      else $error("post strobe pulse width wrong");
   a_irq_enable: assert property (
      irq_rd |=> rdata_out[6] && rdata_out[15])
      else $error("interrupt without enable or special");
   a_irq_ready: assert property (
      irq_rd |=> rdata_out[7])
      else $error("interrupt while busy");
endmodule // err_checker
bind transfer_error_monitor err_checker chk_u (.clk_in, .rst_n_in,
   .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .bus_init_in,
   .power_fail_in, .last_word_in, .pair_pending_in, .single_word_force_out,
   .interrupt_req_out, .error_clear_pulse_out, .post_strobe_out);

//--- verification/drive_model.sv
// behavioural drive on the far side of the drive bus
`timescale 1ns/1ps
module drive_model (
   output logic engaged_out,
   output logic eob_out,
   output logic fault_out,
   output logic strobe_out
);
   initial begin
      engaged_out = 0;
      eob_out = 0;
      fault_out = 0;
      strobe_out = 0;
   end
   // word strobe follows a 125 ns link clock, only while engaged inside a transfer
   task automatic transfer(input int words, input bit fault);
      #50 engaged_out = 1;
      repeat (words) begin
         #62.5 strobe_out = 1;
         #62.5 strobe_out = 0;
      end
      fault_out = fault;
      #62.5 eob_out = 1;
      #62.5 eob_out = 0;
      engaged_out = 0;
      fault_out = 0;
   endtask
endmodule // drive_model

//--- verification/transfer_error_monitor_bench.sv
// self-checking bench for the transfer error monitor
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
   fail_count++; $display("MISMATCH %0t got %h", $time, a); end end
module transfer_error_monitor_bench;
   logic        clk = 0, rst_n = 0, wr = 0, rd = 0, init = 0, pfail = 0;
   logic        full = 0, stg = 1, done = 0, drained = 0, last = 0, pair = 0;
   logic [1:0]  cond = 0;
   logic [5:0]  src = 0;
   logic [3:0]  addr = 0;
   logic [15:0] wdata = 0, rdata, r;
   logic        sw_force, irq, eng, eob, fline, strobe;
   int          fail_count = 0, tests_run = 0;
   transfer_error_monitor #(.TIMEOUT_CYC(50)) dut_u (
      .clk_in(clk), .rst_n_in(rst_n), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .bus_init_in(init),
      .power_fail_in(pfail), .drive_engaged_in(eng), .end_of_block_in(eob),
      .drive_fault_line_in(fline), .word_strobe_in(strobe),
      .drive_attention_in(cond[0]), .control_bus_parity_fault_in(cond[1]),
      .compare_mismatch_in(src[0]), .parity_fault_in(src[1]),
      .absent_drive_in(src[2]), .absent_memory_in(src[3]),
      .program_fault_in(src[4]), .data_bus_parity_fault_in(src[5]),
      .inbound_full_in(full), .staging_valid_in(stg),
      .drive_count_done_in(done), .buffer_drained_in(drained),
      .last_word_in(last), .pair_pending_in(pair),
      .single_word_force_out(sw_force), .interrupt_req_out(irq),
      .error_clear_pulse_out(), .post_strobe_out());
   drive_model drive_u (.engaged_out(eng), .eob_out(eob), .fault_out(fline),
      .strobe_out(strobe));
   initial forever #2.5 clk = ~clk;
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 r = rdata;
   endtask
   task automatic clr;
      wr_reg(4'h1, 16'h0020);
      repeat (2) @(posedge clk);
   endtask
   // model edges may land on clock edges, so step off before checking
   task automatic xfer(input logic [15:0] c, input bit f);
      wr_reg(4'h2, c);
      drive_u.transfer(2, f);
      #1;
   endtask
   task automatic t_sources;
      for (int i = 0; i < 6; i++) begin
         src <= 6'h01 << i;
         rd_reg(4'h0);
         `CHK(r & 16'hc0c0, 16'hc080)
         src <= 0;
         case (i)
            1: init <= 1;
            2: pfail <= 1;
            default: wr_reg(4'h1, 16'h0020);
         endcase
         repeat (3) @(posedge clk);
         init <= 0;
         pfail <= 0;
         repeat (4) @(posedge clk);
         rd_reg(4'h0);
         `CHK(r[14], 1'b0)
      end
   endtask
   task automatic t_defer;
      for (int j = 0; j < 2; j++) begin
         wr_reg(4'h0, 16'h0040);
         cond <= 2'b01 << j;
         wr_reg(4'h2, 16'h0001);
         rd_reg(4'h0);
         `CHK(r[15], 1'b1)
         `CHK(irq, 1'b0)
         wr_reg(4'h2, 16'h0000);
         rd_reg(4'h0);
         `CHK(irq, 1'b1)
         wr_reg(4'h0, 16'h0000);
         rd_reg(4'h0);
         `CHK(irq, 1'b0)
         cond <= 0;
      end
   endtask
   task automatic t_missed;
      wr_reg(4'h2, 16'h0003);
      repeat (70) @(posedge clk);
      rd_reg(4'h1);
      `CHK(r[9], 1'b1)
      rd_reg(4'h0);
      `CHK(r[14], 1'b1)
      wr_reg(4'h0, 16'h4000);
      rd_reg(4'h0);
      `CHK(r[14], 1'b0)
   endtask
   task automatic t_xfer;
      xfer(16'h0009, 1'b0);
      wr_reg(4'h2, 16'h0000);
      repeat (70) @(posedge clk);
      rd_reg(4'h1);
      `CHK(r & 16'h8200, 16'h0000)
      xfer(16'h0009, 1'b0);
      repeat (70) @(posedge clk);
      rd_reg(4'h1);
      `CHK(r[9], 1'b1)
      clr;
   endtask
   task automatic t_late;
      for (int k = 0; k < 4; k++) begin
         {stg, done, full} <= (k == 1) ? 3'b010 : (k > 1) ? 3'b101 : 3'b000;
         xfer((k < 2) ? 16'h0009 : (k == 2) ? 16'h0003 : 16'h0005, 1'b0);
         wr_reg(4'h2, 16'h0000);
         rd_reg(4'h1);
         `CHK(r[15], k != 1)
         clr;
         rd_reg(4'h1);
         `CHK(r[15], 1'b0)
      end
      {stg, done, full} <= 3'b100;
   endtask
   task automatic t_fault;
      {last, pair, drained} <= 3'b110;
      xfer(16'h0003, 1'b1);
      `CHK(sw_force, 1'b1)
      rd_reg(4'h0);
      `CHK(r[14], 1'b0)
      drained <= 1;
      rd_reg(4'h0);
      `CHK(r[14], 1'b1)
      wr_reg(4'h2, 16'h0000);
      clr;
      xfer(16'h0009, 1'b1);
      rd_reg(4'h0);
      `CHK(r[14], 1'b1)
      wr_reg(4'h2, 16'h0000);
   endtask
   task automatic report_and_stop;
      if (fail_count == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1;
      repeat (4) @(posedge clk);
      rd_reg(4'hf);
      `CHK(r, 16'h0000)
      t_sources;
      t_defer;
      t_missed;
      t_xfer;
      t_late;
      t_fault;
      report_and_stop;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      report_and_stop;
   end
endmodule // transfer_error_monitor_bench
